/* common/rebl_class_if.sv */
/*
 * carrier between the bank logger and its error classifier.
 * assumes both ends share one clock domain; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none

interface rebl_class_if;
   import rebl_pkg::*;
   rebl_class_t cls;
   logic        support;
   logic        uncorr;
   logic        ctx_corr;
   logic        signal;
   logic        act_req;
   logic        enable;
   logic        to_exc;

   modport requester  (output cls, support, input uncorr, ctx_corr, signal, act_req, enable, to_exc);
   modport classifier (input cls, support, output uncorr, ctx_corr, signal, act_req, enable, to_exc);
endinterface

`default_nettype wire

/* common/rebl_pkg.sv */
/*
 * constants and types of the recoverable error bank logger:
 * status field positions, register selects, reset values, error classes.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package rebl_pkg;

   // ************************************************************
   // bank_error_status field positions
   // ************************************************************
   localparam int STAT_VALID     = 63;
   localparam int STAT_OVERFLOW  = 62;
   localparam int STAT_UNCORR    = 61;
   localparam int STAT_ENABLE    = 60;
   localparam int STAT_MISC_VLD  = 59;
   localparam int STAT_ADDR_VLD  = 58;
   localparam int STAT_CTX_CORR  = 57;
   localparam int STAT_SIGNAL    = 56;
   localparam int STAT_ACT_REQ   = 55;
   localparam int STAT_CODE_MSB  = 15;

   // ************************************************************
   // global registers
   // ************************************************************
   localparam int         CAP_RECOV_BIT  = 24;
   localparam int         CAP_COUNT_MSB  = 7;
   localparam logic [7:0] CAP_BANK_COUNT = 8'h01;
   localparam int         GSTAT_RESTART  = 0;
   localparam int         GSTAT_IN_PROG  = 2;

   // ************************************************************
   // register selects on the model-specific register port
   // ************************************************************
   localparam logic [2:0] SEL_CAP    = 3'h0;
   localparam logic [2:0] SEL_GSTAT  = 3'h1;
   localparam logic [2:0] SEL_STATUS = 3'h2;
   localparam logic [2:0] SEL_ADDR   = 3'h3;
   localparam logic [2:0] SEL_MISC   = 3'h4;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [63:0] STATUS_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] ADDR_RST   = 64'h0000_0000_0000_0000;
   localparam logic [63:0] MISC_RST   = 64'h0000_0000_0000_0000;
   localparam logic [63:0] GSTAT_RST  = 64'h0000_0000_0000_0000;

   // error classes presented by the detecting logic
   typedef enum logic [2:0] {
      CLS_CORRECTED,
      CLS_NO_ACTION,
      CLS_ACTION_OPT,
      CLS_ACTION_REQ,
      CLS_FATAL
   } rebl_class_t;

endpackage

`default_nettype wire

/* test/rebl_checker.sv */
/*
 * port assertions of the recoverable error bank logger.
 * assumes one clock domain and binding onto rebl_top.
 */
`timescale 1ns/10ps
`default_nettype none

module rebl_checker
#(
   parameter logic RECOV_SUPPORT = 1'h1
)
(
   // clock and reset
   input wire logic                 CLK,
   input wire logic                 RSTN,
   // watched ports
   input wire logic                 ERR_VALID,
   input wire rebl_pkg::rebl_class_t ERR_CLASS,
   input wire logic                 MSR_RD,
   input wire logic [2:0]           MSR_SEL,
   input wire logic [63:0]          MSR_RDATA,
   input wire logic                 MSR_RD_ACK,
   input wire logic                 CORR_INTR,
   input wire logic                 FAULT_EXC
);
   import rebl_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // classes that must raise the exception
   logic exc_cls;
   assign exc_cls = ERR_CLASS == CLS_FATAL || ERR_CLASS == CLS_ACTION_OPT || ERR_CLASS == CLS_ACTION_REQ
                    || (!RECOV_SUPPORT && ERR_CLASS == CLS_NO_ACTION);

   a_read_answer: assert property (MSR_RD |=> MSR_RD_ACK) else $error("read not acknowledged");
   a_ack_cause: assert property (MSR_RD_ACK |-> $past(MSR_RD)) else $error("ack without read");
   a_exc_path: assert property (ERR_VALID && exc_cls |=> FAULT_EXC && !CORR_INTR)
      else $error("exception path missed");
   a_corr_path: assert property (ERR_VALID && !exc_cls |=> CORR_INTR && !FAULT_EXC)
      else $error("corrected path missed");
   a_path_cause: assert property ((CORR_INTR || FAULT_EXC) |-> $past(ERR_VALID))
      else $error("path pulse without error");
   a_cap_support: assert property (MSR_RD && MSR_SEL == SEL_CAP |=> MSR_RDATA[CAP_RECOV_BIT] == RECOV_SUPPORT)
      else $error("support bit wrong");
   a_rdata_hold: assert property (!MSR_RD |=> $stable(MSR_RDATA)) else $error("read data moved");
   a_unmapped_zero: assert property (MSR_RD && MSR_SEL > SEL_MISC |=> MSR_RDATA == 64'h0)
      else $error("unmapped read not zero");

   c_act_req: cover property (ERR_VALID && ERR_CLASS == CLS_ACTION_REQ);
   c_status_rd: cover property (MSR_RD && MSR_SEL == SEL_STATUS ##1 MSR_RD_ACK);
   c_two_errors: cover property (ERR_VALID ##2 ERR_VALID);
endmodule

bind rebl_top rebl_checker #(.RECOV_SUPPORT(RECOV_SUPPORT)) i_chk (.CLK(CLK), .RSTN(RSTN), .ERR_VALID(ERR_VALID),
   .ERR_CLASS(ERR_CLASS), .MSR_RD(MSR_RD), .MSR_SEL(MSR_SEL), .MSR_RDATA(MSR_RDATA), .MSR_RD_ACK(MSR_RD_ACK),
   .CORR_INTR(CORR_INTR), .FAULT_EXC(FAULT_EXC));

`default_nettype wire

/* test/rebl_sw_model.sv */
/*
 * error handler software model on the register port.
 * assumes the port answers a read exactly one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none

module rebl_sw_model
(
   input  wire logic        clk,
   input  wire logic [63:0] rdata,
   input  wire logic        rd_ack,
   output logic             rd,
   output logic             wr,
   output logic [2:0]       sel,
   output logic [63:0]      wdata
);
   import rebl_pkg::*;
   int gap = 0; // each access waits gap + 1 idle cycles first

   // idle port at time zero
   initial
   begin
      rd = 1'h0;
      wr = 1'h0;
      sel = 3'h7;
      wdata = 64'h0;
   end

   // one write, lines scrambled once released
   task wr_reg(input logic [2:0] s, input logic [63:0] d);
      repeat (gap + 1) @(negedge clk);
      sel = s;
      wdata = d;
      wr = 1'h1;
      @(negedge clk);
      wr = 1'h0;
      sel = ~s;
      wdata = ~d;
   endtask

   // one read, answer taken a cycle later
   task rd_reg(input logic [2:0] s, output logic [63:0] d, output logic a);
      repeat (gap + 1) @(negedge clk);
      sel = s;
      rd = 1'h1;
      @(negedge clk);
      rd = 1'h0;
      sel = ~s;
      d = rdata;
      a = rd_ack;
   endtask

   // decision: 0 resume, 1 recover, 2 shut down
   task handle(output int act);
      logic [63:0] st;
      logic [63:0] cap;
      logic [63:0] gs;
      logic        a;
      rd_reg(SEL_CAP, cap, a);
      rd_reg(SEL_STATUS, st, a);
      rd_reg(SEL_GSTAT, gs, a);
      if (!cap[CAP_RECOV_BIT] || st[STAT_CTX_CORR])
         act = 2;
      else if (st[STAT_ACT_REQ] && !st[STAT_ADDR_VLD] && !st[STAT_MISC_VLD])
         act = 2;
      else if (st[STAT_ACT_REQ])
         act = 1;
      else if (!st[STAT_SIGNAL])
         act = 0;
      else if (gs[GSTAT_RESTART])
         act = 0;
      else
         act = 1;
      wr_reg(SEL_STATUS, 64'h0);
   endtask
endmodule

`default_nettype wire

/* test/tb.sv */
/*
 * self-checking bench of the bank logger.
 * assumes rebl_top with recovery support and the handler model.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
   import rebl_pkg::*;
   logic        clk, rstn, err_valid, av, mv, restart_ok, msr_rd, msr_wr, msr_rd_ack, corr_intr, fault_exc;
   rebl_class_t err_class;
   logic [15:0] err_code;
   logic [63:0] err_addr, err_misc, msr_wdata, msr_rdata;
   logic [2:0]  msr_sel;
   int          fails = 0;
   int          checked = 0;
   localparam logic [63:0] OVF = 64'h4000_0000_0000_0000;

   rebl_top i_dut (.CLK(clk), .RSTN(rstn), .ERR_VALID(err_valid), .ERR_CLASS(err_class), .ERR_CODE(err_code),
      .ERR_ADDR_VALID(av), .ERR_ADDR(err_addr), .ERR_MISC_VALID(mv), .ERR_MISC(err_misc),
      .ERR_RESTART_OK(restart_ok), .MSR_RD(msr_rd), .MSR_WR(msr_wr), .MSR_SEL(msr_sel), .MSR_WDATA(msr_wdata),
      .MSR_RDATA(msr_rdata), .MSR_RD_ACK(msr_rd_ack), .CORR_INTR(corr_intr), .FAULT_EXC(fault_exc));
   rebl_sw_model i_sw (.clk(clk), .rdata(msr_rdata), .rd_ack(msr_rd_ack), .rd(msr_rd), .wr(msr_wr),
      .sel(msr_sel), .wdata(msr_wdata));

   task chk(input logic [64:0] got, input logic [64:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task rdc(input logic [2:0] s, input logic [63:0] e);
      logic [63:0] d;
      logic        a;
      i_sw.rd_reg(s, d, a);
      chk({a, d}, {1'h1, e});
   endtask

   // one error pulse, returns {corrected, exception}
   task inject(input rebl_class_t c, input logic [15:0] code, input logic a, input logic m, output logic [1:0] p);
      @(negedge clk);
      err_valid = 1'h1;
      err_class = c;
      err_code = code;
      av = a;
      mv = m;
      err_addr = {48'hA5A5_0000_0000, code};
      @(negedge clk);
      p = {corr_intr, fault_exc};
      err_valid = 1'h0;
      err_code = ~code;
   endtask

   function automatic logic [63:0] exp_st(input rebl_class_t c, input logic [15:0] code, input logic a,
                                          input logic m);
      logic unc;
      unc = c != CLS_CORRECTED;
      exp_st = {1'h1, 1'h0, unc, unc, m, a, c == CLS_FATAL, c == CLS_ACTION_OPT || c == CLS_ACTION_REQ,
                c == CLS_ACTION_REQ, 39'h0, code};
   endfunction

   task t_regs;
      for (int s = 0; s < 8; s++)
         rdc(3'(s), s == 0 ? 64'h0000_0000_0100_0001 : 64'h0);
      i_sw.wr_reg(SEL_CAP, 64'h0);
      i_sw.wr_reg(3'h6, 64'hFFFF_FFFF_FFFF_FFFF);
      rdc(SEL_CAP, 64'h0000_0000_0100_0001);
      rdc(3'h6, 64'h0);
   endtask

   task t_class;
      rebl_class_t c;
      logic [1:0]  p;
      int          act;
      for (int i = 0; i < 5; i++)
      begin
         c = rebl_class_t'(i);
         restart_ok = i[1];
         i_sw.wr_reg(SEL_STATUS, 64'h0);
         inject(c, 16'h0100 + 16'(i), i[0], i[1], p);
         chk({63'h0, p}, (i < 2) ? 65'h2 : 65'h1);
         rdc(SEL_STATUS, exp_st(c, 16'h0100 + 16'(i), i[0], i[1]));
         if (i[0])
            rdc(SEL_ADDR, {48'hA5A5_0000_0000, 16'h0100 + 16'(i)});
         if (i == 3)
            rdc(SEL_GSTAT, 64'h5);
         i_sw.handle(act);
         chk(65'(act), (i == 4) ? 65'h2 : ((i == 3) ? 65'h1 : 65'h0));
      end
   endtask

   task t_sticky;
      logic [1:0] p;
      int         act;
      i_sw.wr_reg(SEL_STATUS, 64'h0);
      inject(CLS_ACTION_REQ, 16'h0ABC, 1'h0, 1'h0, p);
      inject(CLS_NO_ACTION, 16'h0DEF, 1'h1, 1'h1, p);
      chk({63'h0, p}, 65'h2);
      rdc(SEL_STATUS, exp_st(CLS_ACTION_REQ, 16'h0ABC, 1'h0, 1'h0) | OVF);
      i_sw.handle(act);
      chk(65'(act), 65'h2);
      rdc(SEL_STATUS, 64'h0);
   endtask

   task t_over;
      logic [1:0] p;
      i_sw.wr_reg(SEL_STATUS, 64'h0);
      inject(CLS_CORRECTED, 16'h0011, 1'h0, 1'h0, p);
      inject(CLS_NO_ACTION, 16'h0022, 1'h0, 1'h1, p);
      rdc(SEL_STATUS, exp_st(CLS_NO_ACTION, 16'h0022, 1'h0, 1'h1) | OVF);
      inject(CLS_FATAL, 16'h0033, 1'h1, 1'h0, p);
      rdc(SEL_STATUS, exp_st(CLS_FATAL, 16'h0033, 1'h1, 1'h0) | OVF);
   endtask

   task results;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // clock
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // watchdog
   initial
   begin
      repeat (4000) @(posedge clk);
      fails++;
      results;
   end

   // main sequence
   initial
   begin
      rstn = 1'h0;
      err_valid = 1'h0;
      err_class = CLS_CORRECTED;
      err_code = 16'h0;
      av = 1'h0;
      mv = 1'h0;
      err_addr = 64'h0;
      err_misc = 64'h0000_0000_0000_C3C3;
      restart_ok = 1'h0;
      repeat (20) @(negedge clk);
      rstn = 1'h1;
      t_regs;
      t_class;
      t_sticky;
      i_sw.gap = 3;
      t_over;
      results;
   end
endmodule

`default_nettype wire

/* verilog/rebl_classify.sv */
/*
 * maps an error class onto status flag values and a signalling path.
 * assumes the requester holds the class stable within the cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module rebl_classify
(
   rebl_class_if.classifier cif
);
   import rebl_pkg::*;

   // ************************************************************
   // class encoding
   // ************************************************************
   // without recovery support every uncorrected error is fatal
   always_comb
   begin
      cif.uncorr   = 1'b1;
      cif.ctx_corr = 1'b0;
      cif.signal   = 1'b0;
      cif.act_req  = 1'b0;
      cif.enable   = 1'b1;
      cif.to_exc   = 1'b1;
      case (cif.cls)
         CLS_CORRECTED:
         begin
            cif.uncorr = 1'b0;
            cif.enable = 1'b0;
            cif.to_exc = 1'b0;
         end
         CLS_NO_ACTION:
         begin
            cif.ctx_corr = ~cif.support;
            cif.to_exc   = ~cif.support;
         end
         CLS_ACTION_OPT:
         begin
            cif.ctx_corr = ~cif.support;
            cif.signal   = cif.support;
         end
         CLS_ACTION_REQ:
         begin
            cif.ctx_corr = ~cif.support;
            cif.signal   = cif.support;
            cif.act_req  = cif.support;
         end
         default:
         begin
            cif.ctx_corr = 1'b1;
         end
      endcase
   end

endmodule

`default_nettype wire

/* verilog/rebl_sticky.sv */
/*
 * one sticky flag: hardware may only set it, software write or reset clears.
 * assumes set and write are single-cycle qualified strobes.
 */
`timescale 1ns/10ps
`default_nettype none

module rebl_sticky
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic wr,
   input  wire logic wdata,
   output logic      q
);

   logic flag_reg;
   logic flag_next;

   // set wins over a simultaneous software clear
   always_comb
   begin
      flag_next = flag_reg;
      if (wr)
      begin
         flag_next = wdata;
      end
      flag_next = flag_next | set;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
      end
   end

   assign q = flag_reg;

endmodule

`default_nettype wire

/* verilog/rebl_top.sv */
/*
 * recoverable error bank logger: one error-reporting bank with its
 * status, address and misc registers plus the global capability and
 * global status registers, all reached over a model-specific register port.
 * assumes detecting logic presents one error per ERR_VALID pulse and that
 * all inputs are synchronous to CLK.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - capability bit 24 reports recovery support; clear means no recoverable classes
// - recoverable error logs valid=1, uncorrected=1, context-corrupt=0
// - each recoverable error goes to interrupt path or exception by class
// - address/misc valid set only when those registers hold real data
// - error code field records the kind of recoverable error
// - signaling bit 56 set when a recoverable error raises the exception, clear for corrected path
// - action-required bit 55 set when recovery action is mandatory
// - signaling and action-required bits are sticky; only software or reset clears
// - those two bits set only for recoverable errors with support present
// - no-action class: uncorrected, signaling=0, action=0, corrected path
// - action-optional class: signaling=1, enable=1, action=0, exception
// - consumption error: signaling=1, enable=1, action=1, exception
// - corrected error: uncorrected=0, context-corrupt=0, corrected path
// - recoverable replaces corrected; context-corrupt replaces recoverable; else keep first
// - second error into a valid bank always sets overflow
// - every logged error writes its 16-bit code and sets valid
module rebl_top
#(
   parameter logic RECOV_SUPPORT = 1'b1
)
(
   // clock and reset
   input  wire logic         CLK,
   input  wire logic         RSTN,
   // error reports from the detecting logic
   input  wire logic         ERR_VALID,
   input  wire rebl_pkg::rebl_class_t ERR_CLASS,
   input  wire logic [15:0]  ERR_CODE,
   input  wire logic         ERR_ADDR_VALID,
   input  wire logic [63:0]  ERR_ADDR,
   input  wire logic         ERR_MISC_VALID,
   input  wire logic [63:0]  ERR_MISC,
   input  wire logic         ERR_RESTART_OK,
   // model-specific register port
   input  wire logic         MSR_RD,
   input  wire logic         MSR_WR,
   input  wire logic [2:0]   MSR_SEL,
   input  wire logic [63:0]  MSR_WDATA,
   output logic [63:0]       MSR_RDATA,
   output logic              MSR_RD_ACK,
   // signalling paths
   output logic              CORR_INTR,
   output logic              FAULT_EXC
);
   import rebl_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [63:0] status_reg;
   logic [63:0] status_next;
   logic [63:0] addr_reg;
   logic [63:0] addr_next;
   logic [63:0] misc_reg;
   logic [63:0] misc_next;
   logic [63:0] gstat_reg;
   logic [63:0] gstat_next;
   logic [63:0] rdata_reg;
   logic [63:0] rdata_next;
   logic        rd_ack_reg;
   logic        rd_ack_next;
   logic        intr_reg;
   logic        intr_next;
   logic        exc_reg;
   logic        exc_next;
   logic [63:0] cap_word;
   logic [63:0] stat_base;
   logic        wr_status;
   logic        wr_gstat;
   logic        wr_addr;
   logic        wr_misc;
   logic        replace;
   logic        old_valid;
   logic        old_uncorr;
   logic        old_ctx;
   logic        sig_q;
   logic        act_q;
   logic        sig_set;
   logic        act_set;

   rebl_class_if cif ();

   // ************************************************************
   // error classification
   // ************************************************************
   assign cif.cls     = ERR_CLASS;
   assign cif.support = RECOV_SUPPORT;

   rebl_classify u_classify
   (
      .cif (cif)
   );

   // capability word: bank count and recovery support
   always_comb
   begin
      cap_word                = 64'h0000_0000_0000_0000;
      cap_word[CAP_COUNT_MSB:0] = CAP_BANK_COUNT;
      cap_word[CAP_RECOV_BIT] = RECOV_SUPPORT;
   end

   // ************************************************************
   // register write decode
   // ************************************************************
   // capability and unmapped selects get no write strobe at all
   assign wr_status = MSR_WR && (MSR_SEL == SEL_STATUS);
   assign wr_gstat  = MSR_WR && (MSR_SEL == SEL_GSTAT);
   assign wr_addr   = MSR_WR && (MSR_SEL == SEL_ADDR);
   assign wr_misc   = MSR_WR && (MSR_SEL == SEL_MISC);

   // ************************************************************
   // sticky signaling and action-required flags
   // ************************************************************
   // set on every qualifying event, even when the record itself is kept
   assign sig_set   = ERR_VALID & cif.signal;
   assign act_set   = ERR_VALID & cif.act_req;

   rebl_sticky u_sig
   (
      .clk   (CLK),
      .rst_n (RSTN),
      .set   (sig_set),
      .wr    (wr_status),
      .wdata (MSR_WDATA[STAT_SIGNAL]),
      .q     (sig_q)
   );

   rebl_sticky u_act
   (
      .clk   (CLK),
      .rst_n (RSTN),
      .set   (act_set),
      .wr    (wr_status),
      .wdata (MSR_WDATA[STAT_ACT_REQ]),
      .q     (act_q)
   );

   // ************************************************************
   // bank logging with overwrite priority
   // ************************************************************
   // a write in the same cycle lands first, then the event on top
   always_comb
   begin
      stat_base = wr_status ? MSR_WDATA : status_reg;
      // the sticky cells own signaling and action bits, so keep them zero here
      stat_base[STAT_SIGNAL]  = 1'b0;
      stat_base[STAT_ACT_REQ] = 1'b0;
      old_valid  = stat_base[STAT_VALID];
      old_uncorr = stat_base[STAT_UNCORR];
      old_ctx    = stat_base[STAT_CTX_CORR];
      // recoverable over corrected, context-corrupt over recoverable
      replace = !old_valid
              || (cif.uncorr && !old_uncorr)
              || (cif.ctx_corr && old_uncorr && !old_ctx);
      status_next = stat_base;
      addr_next   = wr_addr ? MSR_WDATA : addr_reg;
      misc_next   = wr_misc ? MSR_WDATA : misc_reg;
      if (ERR_VALID)
      begin
         if (replace)
         begin
            status_next                = 64'h0000_0000_0000_0000;
            status_next[STAT_VALID]    = 1'b1;
            status_next[STAT_UNCORR]   = cif.uncorr;
            status_next[STAT_CTX_CORR] = cif.ctx_corr;
            status_next[STAT_ENABLE]   = cif.enable;
            status_next[STAT_ADDR_VLD] = ERR_ADDR_VALID;
            status_next[STAT_MISC_VLD] = ERR_MISC_VALID;
            status_next[STAT_CODE_MSB:0] = ERR_CODE;
            if (ERR_ADDR_VALID)
            begin
               addr_next = ERR_ADDR;
            end
            if (ERR_MISC_VALID)
            begin
               misc_next = ERR_MISC;
            end
         end
         // overflow marks a second error whether or not it replaced the first
         status_next[STAT_OVERFLOW] = old_valid;
      end
   end

   // ************************************************************
   // global status
   // ************************************************************
   // exception raises in-progress and captures restart validity
   always_comb
   begin
      gstat_next = wr_gstat ? MSR_WDATA : gstat_reg;
      if (ERR_VALID && cif.to_exc)
      begin
         gstat_next[GSTAT_IN_PROG] = 1'b1;
         gstat_next[GSTAT_RESTART] = ERR_RESTART_OK;
      end
   end

   // ************************************************************
   // signalling path choice
   // ************************************************************
   // one pulse per error, on exactly one of the two paths
   always_comb
   begin
      intr_next = ERR_VALID && !cif.to_exc;
      exc_next  = ERR_VALID && cif.to_exc;
   end

   // ************************************************************
   // register read
   // ************************************************************
   // one answer per read strobe; data holds until the next read
   always_comb
   begin
      rd_ack_next = MSR_RD;
      rdata_next  = rdata_reg;
      if (MSR_RD)
      begin
         if (MSR_SEL == SEL_CAP)
         begin
            rdata_next = cap_word;
         end
         else if (MSR_SEL == SEL_GSTAT)
         begin
            rdata_next = gstat_reg;
         end
         else if (MSR_SEL == SEL_STATUS)
         begin
            rdata_next = status_reg;
            // sticky bits are merged in only on the way out
            rdata_next[STAT_SIGNAL]  = sig_q;
            rdata_next[STAT_ACT_REQ] = act_q;
         end
         else if (MSR_SEL == SEL_ADDR)
         begin
            rdata_next = addr_reg;
         end
         else if (MSR_SEL == SEL_MISC)
         begin
            rdata_next = misc_reg;
         end
         else
         begin
            rdata_next = 64'h0000_0000_0000_0000;   // unmapped select
         end
      end
   end

   // ************************************************************
   // state registers
   // ************************************************************
   // every top-level output is taken from one of these flops
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         status_reg <= STATUS_RST;
         addr_reg   <= ADDR_RST;
         misc_reg   <= MISC_RST;
         gstat_reg  <= GSTAT_RST;
         rdata_reg  <= 64'h0000_0000_0000_0000;
         rd_ack_reg <= 1'b0;
         intr_reg   <= 1'b0;
         exc_reg    <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         addr_reg   <= addr_next;
         misc_reg   <= misc_next;
         gstat_reg  <= gstat_next;
         rdata_reg  <= rdata_next;
         rd_ack_reg <= rd_ack_next;
         intr_reg   <= intr_next;
         exc_reg    <= exc_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // plain wires from the state registers, no logic after the flops
   assign MSR_RDATA  = rdata_reg;
   assign MSR_RD_ACK = rd_ack_reg;
   assign CORR_INTR  = intr_reg;
   assign FAULT_EXC  = exc_reg;

endmodule

`default_nettype wire
